//--- pkg/timer_pair_pkg.sv
// Constants shared by the paired 8-bit timer channels.
// Assumes a 16-bit register port with one word per address.
package timer_pair_pkg;

  // Word addresses; channel 0 sits in the upper byte of each word
  localparam logic [3:0] ADDR_COUNT    = 4'h0;
  localparam logic [3:0] ADDR_MATCH_A  = 4'h1;
  localparam logic [3:0] ADDR_MATCH_B  = 4'h2;
  localparam logic [3:0] ADDR_CONTROL  = 4'h3;
  localparam logic [3:0] ADDR_SOURCE   = 4'h4;
  localparam logic [3:0] ADDR_STATUS   = 4'h5;

  // Reset values and the count maximum
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] MATCH_RESET   = 8'hff;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] SOURCE_RESET  = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] COUNT_MAX     = 8'hff;

  // channel_control fields
  localparam int CTL_MATCH_B_IRQ_EN = 7;
  localparam int CTL_MATCH_A_IRQ_EN = 6;
  localparam int CTL_WRAP_IRQ_EN    = 5;
  localparam int CTL_CLEAR_LSB      = 3;
  localparam int CTL_CLOCK_LSB      = 0;

  // count_source_control fields
  localparam int SRC_EXT_RESET_LEVEL = 3;
  localparam int SRC_EDGE_PICK       = 1;
  localparam int SRC_DIVISOR_PICK    = 0;

  // channel_ctl_status fields
  localparam int STS_MATCH_B_FLAG = 7;
  localparam int STS_MATCH_A_FLAG = 6;
  localparam int STS_WRAP_FLAG    = 5;
  localparam int STS_ACTION_B_LSB = 2;
  localparam int STS_ACTION_A_LSB = 0;

  // Clear select codes
  localparam logic [1:0] CLEAR_NONE    = 2'h0;
  localparam logic [1:0] CLEAR_MATCH_A = 2'h1;
  localparam logic [1:0] CLEAR_MATCH_B = 2'h2;
  localparam logic [1:0] CLEAR_EXT     = 2'h3;

  // Clock select codes
  localparam logic [2:0] CLK_STOP     = 3'h0;
  localparam logic [2:0] CLK_DIV_LO   = 3'h1;
  localparam logic [2:0] CLK_DIV_MID  = 3'h2;
  localparam logic [2:0] CLK_DIV_HI   = 3'h3;
  localparam logic [2:0] CLK_CASCADE  = 3'h4;
  localparam logic [2:0] CLK_EXTERNAL = 3'h5;

  // Output actions on a compare match
  localparam logic [1:0] ACT_KEEP   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Prescaler: divider bit per tap, taps /2 /8 /32 /64 /1024 /8192
  localparam int PRESCALE_WIDTH = 13;
  localparam int TAP_COUNT      = 6;
  localparam int TAP_BIT [TAP_COUNT] = '{0, 2, 4, 5, 9, 12};

endpackage

//--- rtl/eight_bit_timer_pair.sv
// Two cascadable 8-bit timer channels with their registers.
// Assumes a one-cycle register port and pins synchronous to clk.
//
// Contract
// - 8-bit read/write up-counter per channel
// - Paired 16-bit words, channel 0 upper
// - Wrap from max to zero sets flag
// - Counter resets to zero
// - Compare A match sets match-A flag
// - Compare B match sets match-B flag
// - Compare write suppresses its match detection
// - Match A/B update output by fields
// - Compare registers reset to all ones
// - Control bit 7 gates match-B request
// - Control bit 6 gates match-A request
// - Control bit 5 gates wrap request
// - Clear select: none, match A, B
// - Clear select 11: external edge or level
// - Clock select with internal pick bits
// - Select 000 stops, 101 external edge
// - Prescaled pairs, divisor and edge picks
// - Cascade: ch0 counts ch1 wraps
`timescale 1ns/1ps
module eight_bit_timer_pair
  import timer_pair_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  input  wire logic [1:0]  bus_be,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [15:0] bus_rdata,
  input  wire logic [1:0]  ext_count_clock_pin,
  input  wire logic [1:0]  ext_clear_pin,
  output logic      [1:0]  timer_out_pin,
  output logic      [1:0]  match_a_irq,
  output logic      [1:0]  match_b_irq,
  output logic      [1:0]  wrap_irq
);

  // Per-channel registers, index = channel
  logic [7:0] count_value_q      [2];   // Counters
  logic [7:0] match_a_value_q    [2];   // Compare A values
  logic [7:0] match_b_value_q    [2];   // Compare B values
  logic [7:0] channel_control_q  [2];   // Enables, clear and clock select
  logic [7:0] count_source_q     [2];   // Internal picks, reset-input mode
  logic [2:0] flags_q            [2];   // {match_b, match_a, wrap}
  logic [3:0] out_action_q       [2];   // {action_b, action_a}
  logic [1:0] eq_a_q;                   // Last compare A result
  logic [1:0] eq_b_q;                   // Last compare B result
  logic [1:0] timer_out_q;              // Pin levels
  logic [1:0] irq_a_q;                  // Requests
  logic [1:0] irq_b_q;
  logic [1:0] irq_w_q;
  logic [15:0] rdata_q;                 // Read data, stands one cycle

  // Events shared between channels for cascading; channel 0 reads the
  // wrap of channel 1 and channel 1 the match A of channel 0
  logic [1:0] match_a_ev;   // Compare A match this cycle
  logic [1:0] match_b_ev;   // Compare B match this cycle
  logic [1:0] wrap_ev;      // Counter wraps this cycle
  logic [1:0] count_tick;   // Selected count edge
  logic [1:0] clear_now;    // Clear condition this cycle

  // Prescaler taps
  // One divider serves both channels, so their prescaled ticks stay in step
  logic [TAP_COUNT-1:0] pre_rise;
  logic [TAP_COUNT-1:0] pre_fall;

  prescale_ticks u_prescale (
    .clk       (clk),
    .rst       (rst),
    .rise_tick (pre_rise),
    .fall_tick (pre_fall)
  );

  for (genvar i = 0; i < 2; i++) begin : g_ch
    // Channel 0 owns the upper byte lane, channel 1 the lower
    localparam int LANE = 1 - i;

    logic       lane_wr;       // Write reaches this channel's byte
    logic [7:0] wbyte;         // Byte written to this channel
    logic       wr_count;
    logic       wr_match_a;
    logic       wr_match_b;
    logic       wr_status;
    logic       eq_a;
    logic       eq_b;
    logic       ext_rise;      // Rising edge on the clock pin
    logic       clr_rise;      // Rising edge on the clear pin
    logic [2:0] clk_sel;
    logic [1:0] clr_sel;
    logic [2:0] tap_idx;       // Prescaler tap for this pick
    logic       pre_tick;
    logic       out_d;
    logic [2:0] flag_set;
    logic [2:0] flag_keep;

    // Byte-lane write decode; a cleared enable leaves this channel alone.
    // Reads ignore the enables and always return both channels.
    assign lane_wr    = bus_wr & bus_be[LANE];
    assign wbyte      = bus_wdata[LANE*8 +: 8];
    assign wr_count   = lane_wr & (bus_addr == ADDR_COUNT);
    assign wr_match_a = lane_wr & (bus_addr == ADDR_MATCH_A);
    assign wr_match_b = lane_wr & (bus_addr == ADDR_MATCH_B);
    assign wr_status  = lane_wr & (bus_addr == ADDR_STATUS);
    assign clk_sel    = channel_control_q[i][CTL_CLOCK_LSB +: 3];
    assign clr_sel    = channel_control_q[i][CTL_CLEAR_LSB +: 2];

    // Count pin edge; the pin is taken as already synchronous to clk
    pin_rise u_clk_pin (
      .clk  (clk),
      .rst  (rst),
      .pin  (ext_count_clock_pin[i]),
      .rise (ext_rise)
    );

    // Clear pin edge, used when the clear pin acts on its rising edge
    pin_rise u_clr_pin (
      .clk  (clk),
      .rst  (rst),
      .pin  (ext_clear_pin[i]),
      .rise (clr_rise)
    );

    // Comparators; a compare write blanks its own match this cycle
    assign eq_a = (count_value_q[i] == match_a_value_q[i]) & ~wr_match_a;
    assign eq_b = (count_value_q[i] == match_b_value_q[i]) & ~wr_match_b;

    // Only the first cycle of equality is a match, so a slow count
    // does not fire the output action again and again
    assign match_a_ev[i] = eq_a & ~eq_a_q[i];
    assign match_b_ev[i] = eq_b & ~eq_b_q[i];

    // Remember comparator results
    always_ff @(posedge clk) begin
      if (rst) begin
        eq_a_q[i] <= 1'b0;
        eq_b_q[i] <= 1'b0;
      end else begin
        eq_a_q[i] <= eq_a;
        eq_b_q[i] <= eq_b;
      end
    end

    // Tap index: pair from the select, divisor pick set takes smaller divisor.
    // Codes 000 and 100 would point past the last tap, so all codes outside 001 to 011 park on tap 0;
    // the count select ignores the prescaler for those codes anyway.
    always_comb begin
      tap_idx = 3'h0;
      if (clk_sel == CLK_DIV_LO || clk_sel == CLK_DIV_MID || clk_sel == CLK_DIV_HI) begin
        tap_idx = {clk_sel[1:0] - 2'h1, ~count_source_q[i][SRC_DIVISOR_PICK]};
      end
    end
    // Edge pick chooses the falling edge of the tap
    assign pre_tick = count_source_q[i][SRC_EDGE_PICK]
                    ? pre_fall[tap_idx] : pre_rise[tap_idx];

    // Count edge per clock select
    always_comb begin
      unique case (clk_sel)
        CLK_STOP:     count_tick[i] = 1'b0;
        CLK_DIV_LO,
        CLK_DIV_MID,
        CLK_DIV_HI:   count_tick[i] = pre_tick;
        // Channel 0 counts channel 1 wraps; channel 1 counts matches A
        CLK_CASCADE:  count_tick[i] = (i == 0) ? wrap_ev[1] : match_a_ev[0];
        CLK_EXTERNAL: count_tick[i] = ext_rise;
        default:      count_tick[i] = 1'b0;  // Reserved codes do not count
      endcase
    end

    // Clear condition per clear select
    // Level mode clears on every cycle the pin is high, so the count sits at zero
    always_comb begin
      unique case (clr_sel)
        CLEAR_NONE:    clear_now[i] = 1'b0;
        CLEAR_MATCH_A: clear_now[i] = match_a_ev[i];
        CLEAR_MATCH_B: clear_now[i] = match_b_ev[i];
        CLEAR_EXT:     clear_now[i] = count_source_q[i][SRC_EXT_RESET_LEVEL]
                                    ? ext_clear_pin[i] : clr_rise;
      endcase
    end

    // Wrap only when a real count edge leaves the maximum
    assign wrap_ev[i] = count_tick[i] & ~clear_now[i] & ~wr_count
                      & (count_value_q[i] == COUNT_MAX);

    // Counter: bus write, then clear, then count
    // A count edge in the cycle of a bus write is lost; the written value wins
    always_ff @(posedge clk) begin
      if (rst) begin
        count_value_q[i] <= COUNT_RESET;
      end else if (wr_count) begin
        count_value_q[i] <= wbyte;
      end else if (clear_now[i]) begin
        count_value_q[i] <= COUNT_RESET;
      end else if (count_tick[i]) begin
        count_value_q[i] <= count_value_q[i] + 8'h01;
      end
    end

    // Compare values
    always_ff @(posedge clk) begin
      if (rst) begin
        match_a_value_q[i] <= MATCH_RESET;
        match_b_value_q[i] <= MATCH_RESET;
      end else begin
        if (wr_match_a) begin
          match_a_value_q[i] <= wbyte;
        end
        if (wr_match_b) begin
          match_b_value_q[i] <= wbyte;
        end
      end
    end

    // Control and source control
    always_ff @(posedge clk) begin
      if (rst) begin
        channel_control_q[i] <= CONTROL_RESET;
        count_source_q[i]    <= SOURCE_RESET;
      end else begin
        if (lane_wr && bus_addr == ADDR_CONTROL) begin
          channel_control_q[i] <= wbyte;
        end
        if (lane_wr && bus_addr == ADDR_SOURCE) begin
          // Reserved bits are not stored and read as zero
          count_source_q[i] <= wbyte & 8'h0b;
        end
      end
    end

    // Flag sources in field order {match_b, match_a, wrap}
    assign flag_set = {match_b_ev[i], match_a_ev[i], wrap_ev[i]};
    // Writing 0 to a flag clears it; writing 1 leaves it
    assign flag_keep = wr_status
                     ? {wbyte[STS_MATCH_B_FLAG], wbyte[STS_MATCH_A_FLAG], wbyte[STS_WRAP_FLAG]}
                     : 3'h7;

    // Sticky flags; a new event wins over a clear in the same cycle
    // Software reads a 1, then writes 0 to clear only that flag
    always_ff @(posedge clk) begin
      if (rst) begin
        flags_q[i] <= STATUS_RESET[STS_WRAP_FLAG +: 3];
      end else begin
        flags_q[i] <= (flags_q[i] & flag_keep) | flag_set;
      end
    end

    // Output action fields
    always_ff @(posedge clk) begin
      if (rst) begin
        out_action_q[i] <= STATUS_RESET[3:0];
      end else if (wr_status) begin
        out_action_q[i] <= wbyte[3:0];
      end
    end

    // Pin level: match A action first, then match B on top
    always_comb begin
      out_d = timer_out_q[i];
      if (match_a_ev[i]) begin
        unique case (out_action_q[i][STS_ACTION_A_LSB +: 2])
          ACT_KEEP:   out_d = out_d;
          ACT_LOW:    out_d = 1'b0;
          ACT_HIGH:   out_d = 1'b1;
          ACT_TOGGLE: out_d = ~out_d;
        endcase
      end
      if (match_b_ev[i]) begin
        unique case (out_action_q[i][STS_ACTION_B_LSB +: 2])
          ACT_KEEP:   out_d = out_d;
          ACT_LOW:    out_d = 1'b0;
          ACT_HIGH:   out_d = 1'b1;
          ACT_TOGGLE: out_d = ~out_d;
        endcase
      end
    end

    // Output pin register
    // The pin resets low; software reaches another level through a match
    always_ff @(posedge clk) begin
      if (rst) begin
        timer_out_q[i] <= 1'b0;
      end else begin
        timer_out_q[i] <= out_d;
      end
    end

    // Requests follow flag and enable, one cycle behind the flag
    // The extra stage keeps each request straight from a flip-flop
    always_ff @(posedge clk) begin
      if (rst) begin
        irq_b_q[i] <= 1'b0;
        irq_a_q[i] <= 1'b0;
        irq_w_q[i] <= 1'b0;
      end else begin
        irq_b_q[i] <= flags_q[i][2] & channel_control_q[i][CTL_MATCH_B_IRQ_EN];
        irq_a_q[i] <= flags_q[i][1] & channel_control_q[i][CTL_MATCH_A_IRQ_EN];
        irq_w_q[i] <= flags_q[i][0] & channel_control_q[i][CTL_WRAP_IRQ_EN];
      end
    end
  end

  // Read multiplexer: channel 0 upper byte, channel 1 lower
  // Spare status bit 4 and reserved source bits read as zero
  logic [15:0] rdata_d;

  always_comb begin
    unique case (bus_addr)
      ADDR_COUNT:   rdata_d = {count_value_q[0], count_value_q[1]};
      ADDR_MATCH_A: rdata_d = {match_a_value_q[0], match_a_value_q[1]};
      ADDR_MATCH_B: rdata_d = {match_b_value_q[0], match_b_value_q[1]};
      ADDR_CONTROL: rdata_d = {channel_control_q[0], channel_control_q[1]};
      ADDR_SOURCE:  rdata_d = {count_source_q[0], count_source_q[1]};
      ADDR_STATUS:  rdata_d = {flags_q[0], 1'b0, out_action_q[0],
                               flags_q[1], 1'b0, out_action_q[1]};
      default:      rdata_d = 16'h0000;  // Unmapped reads as zero
    endcase
  end

  // Read data stands only in the cycle after the strobe
  // Zero between reads, so stale data is never taken for an answer
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (bus_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign bus_rdata     = rdata_q;
  assign timer_out_pin = timer_out_q;
  assign match_a_irq   = irq_a_q;
  assign match_b_irq   = irq_b_q;
  assign wrap_irq      = irq_w_q;

endmodule // eight_bit_timer_pair

//--- rtl/pin_rise.sv
// Rising-edge detector for one pin input.
// Assumes the pin is synchronous to clk.
`timescale 1ns/1ps
module pin_rise (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      rise
);

  logic last_q;   // Pin level one cycle ago

  // Remember the pin level
  always_ff @(posedge clk) begin
    if (rst) begin
      last_q <= 1'b0;
    end else begin
      last_q <= pin;
    end
  end

  assign rise = pin & ~last_q;

endmodule // pin_rise

//--- rtl/prescale_ticks.sv
// Free-running divider of the peripheral clock with edge ticks.
// Assumes one clock; ticks are one-cycle pulses.
`timescale 1ns/1ps
module prescale_ticks
  import timer_pair_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  output logic      [TAP_COUNT-1:0] rise_tick,
  output logic      [TAP_COUNT-1:0] fall_tick
);

  logic [PRESCALE_WIDTH-1:0] div_q;   // Divider chain
  logic [TAP_COUNT-1:0]      tap_q;   // Tap levels, one cycle late

  // Divider advances every cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Taps compare the divider bit with its last value
  for (genvar t = 0; t < TAP_COUNT; t++) begin : g_tap
    always_ff @(posedge clk) begin
      if (rst) begin
        tap_q[t] <= 1'b0;
      end else begin
        tap_q[t] <= div_q[TAP_BIT[t]];
      end
    end
    assign rise_tick[t] = div_q[TAP_BIT[t]] & ~tap_q[t];
    assign fall_tick[t] = ~div_q[TAP_BIT[t]] & tap_q[t];
  end

endmodule // prescale_ticks

//--- verification/tb_eight_bit_timer_pair.sv
// Self-checking bench for the paired 8-bit timer channels.
// Assumes the package register map; pins driven synchronously.
`timescale 1ns/1ps
module tb_eight_bit_timer_pair;
  import timer_pair_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  bus_addr = 4'h0;
  logic [15:0] bus_wdata = 16'h0000;
  logic [1:0]  bus_be = 2'h0;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [1:0]  cnt_pin = 2'h0;
  logic [1:0]  clr_pin = 2'h0;
  logic [15:0] bus_rdata;
  logic [1:0]  out_pin, a_irq, b_irq, w_irq;
  int          mismatches = 0;
  int          compares = 0;
  int          a, b;
  logic [15:0] rv, d;
  logic [1:0]  be;
  logic        pexp = 1'b0;
  // Expectation tables
  logic [15:0] mdl [3] = '{16'h0000, 16'hffff, 16'hffff};
  logic [7:0]  cexp [3] = '{8'h06, 8'h00, 8'h02};
  logic [1:0]  acts [5] = '{2'h2, 2'h1, 2'h3, 2'h0, 2'h3};
  logic [2:0]  psel [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3};
  logic [1:0]  psrc [6] = '{2'h1, 2'h0, 2'h3, 2'h2, 2'h3, 2'h0};
  logic [7:0]  pcnt [6] = '{8'h80, 8'h20, 8'h08, 8'h04, 8'h01, 8'h01};
  int          pwin [6] = '{256, 256, 256, 256, 1024, 8192};

  always #25 clk = ~clk;

  eight_bit_timer_pair i_dut (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_count_clock_pin(cnt_pin),
    .ext_clear_pin(clr_pin), .timer_out_pin(out_pin), .match_a_irq(a_irq), .match_b_irq(b_irq), .wrap_irq(w_irq));

  // Byte-lane merge of a word write
  function automatic logic [15:0] lane(logic [15:0] old, logic [15:0] nw, logic [1:0] en);
    return {en[1] ? nw[15:8] : old[15:8], en[0] ? nw[7:0] : old[7:0]};
  endfunction
  // Pin level after a match with a given action
  function automatic logic pin_next(logic [1:0] act, logic old);
    case (act)
      ACT_LOW: return 1'b0;
      ACT_HIGH: return 1'b1;
      ACT_TOGGLE: return ~old;
      default: return old;
    endcase
  endfunction

  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] wd, input logic [1:0] en = 2'h3);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= ad;
    bus_wdata <= wd;
    bus_be <= en;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] ad);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= ad;
    @(posedge clk);
    bus_rd <= 1'b0;
    @(negedge clk);
    rv = bus_rdata;
  endtask
  // Slow clean rises so every edge is seen
  task automatic pulse(input logic [1:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      cnt_pin <= m;
      repeat (2) @(posedge clk);
      cnt_pin <= 2'h0;
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'haf4a));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (a = 0; a < 16; a++) begin
      rd(a[3:0]);
      check("reset word", rv, (a == 1 || a == 2) ? 16'hffff : 16'h0000);
    end
    // Random lanes with clocks stopped
    for (a = 0; a < 24; a++) begin
      b = $urandom % 3;
      d = 16'($urandom);
      be = 2'($urandom);
      wr(b[3:0], d, be);
      mdl[b] = lane(mdl[b], d, be);
      rd(b[3:0]);
      check("lane word", rv, mdl[b]);
    end
    d = 16'($urandom);
    wr(ADDR_SOURCE, d);
    rd(ADDR_SOURCE);
    check("source word", rv, d & 16'h0b0b);
    wr(ADDR_SOURCE, 16'h0000);
    // External count through wrap; ch1 stopped
    wr(ADDR_MATCH_A, 16'hffff);
    wr(ADDR_MATCH_B, 16'hffff);
    wr(ADDR_COUNT, 16'hfe00);
    wr(ADDR_STATUS, 16'h0000);
    wr(ADDR_CONTROL, 16'h2500);
    pulse(2'h3, 2);
    rd(ADDR_COUNT);
    check("count wrap", rv, 16'h0000);
    rd(ADDR_STATUS);
    check("flags wrap", rv, 16'he000);
    check("irq wrap only", {10'h0, a_irq, b_irq, w_irq}, 16'h0001);
    wr(ADDR_CONTROL, 16'he500);
    repeat (2) @(negedge clk);
    check("irq all on", {10'h0, a_irq, b_irq, w_irq}, 16'h0015);
    wr(ADDR_CONTROL, 16'h0500);
    wr(ADDR_STATUS, 16'h0000);
    rd(ADDR_STATUS);
    check("flags cleared", rv, 16'h0000);
    // Clear select table on ch1
    wr(ADDR_MATCH_A, 16'hff03);
    wr(ADDR_MATCH_B, 16'hff04);
    for (a = 0; a < 3; a++) begin
      wr(ADDR_CONTROL, {11'h0, a[1:0], CLK_EXTERNAL});
      wr(ADDR_COUNT, 16'h0000);
      pulse(2'h2, 6);
      rd(ADDR_COUNT);
      check("clear select", rv, {8'h00, cexp[a]});
    end
    rd(ADDR_STATUS);
    check("match flags", rv, 16'h00c0);
    // Pin clear: edge, then level
    wr(ADDR_CONTROL, 16'h0018);
    wr(ADDR_COUNT, 16'h0050);
    clr_pin <= 2'h2;
    rd(ADDR_COUNT);
    check("edge clear", rv, 16'h0000);
    wr(ADDR_COUNT, 16'h0020);
    rd(ADDR_COUNT);
    check("edge held", rv, 16'h0020);
    wr(ADDR_SOURCE, 16'h0008);
    rd(ADDR_COUNT);
    check("level clear", rv, 16'h0000);
    wr(ADDR_SOURCE, 16'h0000);
    clr_pin <= 2'h0;
    // Output actions on ch0 match A
    wr(ADDR_CONTROL, 16'h0d00);
    wr(ADDR_MATCH_A, 16'h0103);
    for (a = 0; a < 5; a++) begin
      wr(ADDR_STATUS, {6'h0, acts[a], 8'h00});
      pulse(2'h1, 1);
      pexp = pin_next(acts[a], pexp);
      check("out pin", {14'h0, out_pin}, {15'h0, pexp});
    end
    // Cascade: ch0 counts ch1 wraps
    wr(ADDR_CONTROL, 16'h0405);
    wr(ADDR_COUNT, 16'h12ff);
    pulse(2'h2, 1);
    rd(ADDR_COUNT);
    check("cascade", rv, 16'h1300);
    // Prescaled counts over a window that is a whole number of tap periods
    for (a = 0; a < 6; a++) begin
      wr(ADDR_SOURCE, {14'h0, psrc[a]});
      wr(ADDR_CONTROL, {13'h0, psel[a]});
      rd(ADDR_COUNT);
      b = rv[7:0];
      repeat (pwin[a] - 2) @(posedge clk);
      rd(ADDR_COUNT);
      check("prescale", {8'h00, rv[7:0] - b[7:0]}, {8'h00, pcnt[a]});
    end
    end_of_test();
  end
endmodule // tb_eight_bit_timer_pair

//--- verification/timer_pair_sva.sv
// Port checker for the paired 8-bit timer channels.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module timer_pair_sva
  import timer_pair_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [1:0]  bus_be,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic [1:0]  timer_out_pin,
  input wire logic [1:0]  match_a_irq,
  input wire logic [1:0]  match_b_irq,
  input wire logic [1:0]  wrap_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Read data stands only after a read
  a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 16'h0000) else $error("rdata not idle");
  a_unmapped_zero: assert property (bus_rd && bus_addr > ADDR_STATUS |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_source_reserved: assert property (bus_rd && bus_addr == ADDR_SOURCE |=> (bus_rdata & 16'hf4f4) == 16'h0000)
    else $error("source spare bits set");
  a_status_spare: assert property (bus_rd && bus_addr == ADDR_STATUS |=> (bus_rdata & 16'h1010) == 16'h0000)
    else $error("status spare bit set");
  // Outputs quiet on leaving reset
  a_reset_quiet: assert property ($fell(rst) |-> timer_out_pin == 2'h0 && (match_a_irq | match_b_irq | wrap_irq) == 2'h0)
    else $error("outputs busy after reset");
  // Enable cleared: request gone two edges later
  a_b_gate_off: assert property (bus_wr && bus_addr == ADDR_CONTROL && bus_be[1] && !bus_wdata[15] |=> ##1 !match_b_irq[0])
    else $error("match b request not gated");
  a_a_gate_off: assert property (bus_wr && bus_addr == ADDR_CONTROL && bus_be[0] && !bus_wdata[6] |=> ##1 !match_a_irq[1])
    else $error("match a request not gated");
  a_wrap_gate_off: assert property (bus_wr && bus_addr == ADDR_CONTROL && bus_be[1] && !bus_wdata[13] |=> ##1 !wrap_irq[0])
    else $error("wrap request not gated");
  // Sticky flag: request holds without bus writes
  a_irq_sticky: assert property (match_a_irq[0] && !bus_wr && !$past(bus_wr) |=> match_a_irq[0])
    else $error("request dropped alone");
endmodule // timer_pair_sva

bind eight_bit_timer_pair timer_pair_sva i_sva (.clk(clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_be(bus_be), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .timer_out_pin(timer_out_pin),
  .match_a_irq(match_a_irq), .match_b_irq(match_b_irq), .wrap_irq(wrap_irq));
